// ---- gp_bus_cycle_sizing_wait.sv ----
/*
  general purpose bus cycle controller: byte lanes, bus sizing,
  strobe timing with ready stretch, bus reset and enable ordering.
  assumes one internal processor request at a time, held until done_o.
*/
// Chosen here: the plain strobed port.
// Function
// RULE1 - byte high enable and address bit zero encode lane use per cycle
// RULE2 - memory mapped peripherals get memory strobes instead of io strobes
// RULE3 - each chip select holds its own 8 or 16 bit width
// RULE4 - width is 16 if either sizing input or programming says 16
// RULE5 - asserted sizing input gives 16 bit size indication to processor
// RULE6 - sizing inputs never change strobe offset or pulse timing
// RULE7 - peripheral asserts sizing input only while address is valid
// RULE8 - static waits from timing register, dynamic waits from ready
// RULE9 - ready only lengthens a cycle, never shortens it
// RULE10 - strobes stay for the full programmed period, ready delay after
// RULE11 - peripheral drops ready 45 ns early and holds it 30 ns
// RULE12 - cycle stretches as long as ready stays low
// RULE13 - ready synchronised, strobes end on ready high and pulse expiry
// RULE14 - split wide accesses block other processor and dma cycles
// RULE15 - every access on this bus is noncacheable
// RULE16 - external interrupt lines bypass the bus controller
// RULE17 - after reset internal bus and io holes on, chip selects off
// RULE18 - external bus stays off until region decoding is initialised
// RULE19 - bus reset bit drives external bus reset, system reset also
// RULE20 - peripherals return to reset while bus reset is asserted
// RULE21 - software enables regions, pins, timing, then width in order
// RULE22 - optional strobe qualification and echo mode under software
// RULE23 - wide access to 8 bit device gives 8 bit size indication
// RULE24 - ready already high ends strobe exactly at programmed width
`default_nettype none
module gp_bus_cycle_sizing_wait
  import gp_bus_pkg::*;
#(
  parameter int NUM_CS = 8
)(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [11:0]       reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // processor side
  input  wire logic              cpu_req_i,
  input  wire logic              cpu_write_i,
  input  wire logic              cpu_mem_i,
  input  wire logic [2:0]        cpu_cs_i,
  input  wire logic              cpu_a0_i,
  input  wire logic              cpu_wide_i,
  input  wire logic              cpu_split_i,
  output logic                   done_o,
  output logic                   size_sixteen_indicate_o,
  output logic                   size_eight_indicate_o,
  output logic                   noncacheable_o,
  output logic                   cpu_lock_o,
  // external bus
  output logic                   byte_high_enable_o,
  output logic                   addr_bit_zero_o,
  output logic                   io_read_strobe_o,
  output logic                   io_write_strobe_o,
  output logic                   mem_read_strobe_o,
  output logic                   mem_write_strobe_o,
  output logic [NUM_CS-1:0]      ext_chip_selects_o,
  output logic                   ext_bus_reset_out_o,
  output logic                   echo_enable_o,
  input  wire logic              io_wide_select_in_i,
  input  wire logic              mem_wide_select_in_i,
  input  wire logic              wait_ready_in_i,
  input  wire logic [10:0]       ext_irq_lines_i,
  output logic      [10:0]       irq_ctrl_lines_o
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  echo_r;
  logic [7:0]  width_r;
  logic [7:0]  qual_r;
  logic [7:0]  pinfn_r;
  logic [7:0]  reset_configuration_r;
  logic [7:0]  timing_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  rdata_r;

  wire wr_echo   = reg_wr_i && (reg_addr_i == OFS_BUS_ECHO_CONTROL);
  wire wr_width  = reg_wr_i && (reg_addr_i == OFS_CHIPSEL_WIDTH_SELECT);
  wire wr_qual   = reg_wr_i && (reg_addr_i == OFS_CHIPSEL_STROBE_QUALIFY);
  wire wr_pinfn  = reg_wr_i && (reg_addr_i == OFS_CHIPSEL_PIN_FUNCTION);
  wire wr_reset_configuration = reg_wr_i && (reg_addr_i == OFS_RESET_CONFIGURATION);
  wire wr_timing = reg_wr_i && (reg_addr_i == OFS_STROBE_TIMING);
  wire wr_ctrl   = reg_wr_i && (reg_addr_i == OFS_BUS_CONTROL);

  cyc_state_t  state_r;
  cyc_state_t  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        wide_r;
  logic        ready_seen;

  wire ext_enable = ctrl_r[REGIONS_DONE_POS]; // RULE18
  wire busy       = (state_r != ST_IDLE);
  wire [7:0] status_w = {5'h00, wide_r, busy, ext_enable};

  always_comb begin
    unique case (reg_addr_i)
      OFS_BUS_ECHO_CONTROL:       rdata_r = echo_r;
      OFS_CHIPSEL_WIDTH_SELECT:   rdata_r = width_r;
      OFS_CHIPSEL_STROBE_QUALIFY: rdata_r = qual_r;
      OFS_CHIPSEL_PIN_FUNCTION:   rdata_r = pinfn_r;
      OFS_RESET_CONFIGURATION:    rdata_r = reset_configuration_r;
      OFS_STROBE_TIMING:          rdata_r = timing_r;
      OFS_BUS_CONTROL:            rdata_r = ctrl_r;
      OFS_BUS_STATUS:             rdata_r = status_w;
      default:                    rdata_r = 8'h00;
    endcase
  end

  // chip selects off and bus reset asserted by system reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      echo_r   <= ZERO_RESET;
      width_r  <= ZERO_RESET;
      qual_r   <= ZERO_RESET;
      pinfn_r  <= ZERO_RESET; // RULE17
      reset_configuration_r <= ZERO_RESET;
      timing_r <= TIMING_RESET;
      ctrl_r   <= CTRL_RESET; // RULE17
      reg_rdata_o <= 8'h00;
    end else begin
      if (wr_echo)   echo_r   <= reg_wdata_i; // RULE22
      if (wr_width)  width_r  <= reg_wdata_i; // RULE3
      if (wr_qual)   qual_r   <= reg_wdata_i; // RULE22
      if (wr_pinfn)  pinfn_r  <= reg_wdata_i;
      if (wr_reset_configuration) reset_configuration_r <= reg_wdata_i; // RULE19
      if (wr_timing) timing_r <= reg_wdata_i; // RULE8
      if (wr_ctrl)   ctrl_r   <= reg_wdata_i;
      reg_rdata_o <= reg_rd_i ? rdata_r : 8'h00;
    end
  end

  // bus reset also held by system reset itself
  assign ext_bus_reset_out_o = rst_i | reset_configuration_r[BUS_RESET_BIT_POS]; // RULE19
  assign echo_enable_o       = echo_r[0]; // RULE22
  assign irq_ctrl_lines_o    = ext_irq_lines_i; // RULE16
  assign noncacheable_o      = 1'b1; // RULE15

  // ****************************************
  // ready synchroniser and sizing
  // ****************************************
  ready_sync u_ready_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (wait_ready_in_i),
    .sync_o    (ready_seen)
  );

  wire dyn_wide  = io_wide_select_in_i | mem_wide_select_in_i;
  wire prog_wide = width_r[cpu_cs_i];                           // RULE3
  wire res_wide  = dyn_wide | prog_wide;                         // RULE4
  wire [3:0] offs_cnt  = timing_r[OFFSET_LSB +: 4];
  wire [3:0] pulse_cnt = timing_r[PULSE_LSB +: 4];
  wire start = cpu_req_i && !busy && ext_enable;

  // ****************************************
  // cycle sequencer
  // ****************************************
  // sizing never touches the counts below, only the lane and size indication outputs and the status wide bit
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_IDLE: if (start) begin
        state_nxt = ST_OFFSET;
        cnt_nxt   = offs_cnt; // RULE6
      end
      ST_OFFSET: if (cnt_r == 4'h0) begin
        state_nxt = ST_PULSE;
        cnt_nxt   = pulse_cnt; // RULE8
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      ST_PULSE: if (cnt_r != 4'h0) begin
        cnt_nxt = cnt_r - 4'h1; // RULE10
      end else if (ready_seen) begin
        state_nxt = ST_IDLE; // RULE24
      end else begin
        state_nxt = ST_WAIT; // RULE9
      end
      ST_WAIT: if (ready_seen) begin
        state_nxt = ST_IDLE; // RULE13
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      wide_r  <= 1'b0;
    end else begin
      state_r <= state_nxt; // RULE12
      cnt_r   <= cnt_nxt;
      if (start) wide_r <= prog_wide;
      else if (busy && dyn_wide) wide_r <= 1'b1; // RULE4
    end
  end

  wire strobe_on = (state_r == ST_PULSE) || (state_r == ST_WAIT);
  wire cur_wide  = wide_r | dyn_wide;
  assign done_o  = busy && (state_nxt == ST_IDLE);

  // upper byte of an 8-bit device appears as 1/1
  assign byte_high_enable_o = !(busy && cur_wide && (cpu_wide_i || cpu_a0_i)); // RULE1
  assign addr_bit_zero_o    = busy && cpu_a0_i && !(cur_wide && cpu_wide_i); // RULE1

  assign io_read_strobe_o   = strobe_on && !cpu_mem_i && !cpu_write_i;
  assign io_write_strobe_o  = strobe_on && !cpu_mem_i &&  cpu_write_i;
  assign mem_read_strobe_o  = strobe_on &&  cpu_mem_i && !cpu_write_i; // RULE2
  assign mem_write_strobe_o = strobe_on &&  cpu_mem_i &&  cpu_write_i; // RULE2

  // qualified selects follow the strobes, others span the cycle
  wire cs_live = qual_r[cpu_cs_i] ? strobe_on : busy; // RULE22
  always_comb begin
    ext_chip_selects_o = '0;
    ext_chip_selects_o[cpu_cs_i] = cs_live && pinfn_r[cpu_cs_i];
  end

  assign size_sixteen_indicate_o = busy && cur_wide; // RULE5
  assign size_eight_indicate_o   = busy && !cur_wide; // RULE23
  // held for the whole split sequence; long waits starve the system bus
  assign cpu_lock_o = busy || (cpu_split_i && cpu_req_i); // RULE14

  // ****************************************
  // assertions
  // ****************************************
  property p_lane_wide;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy && cur_wide && cpu_wide_i |-> !byte_high_enable_o && !addr_bit_zero_o;
  endproperty
  a_lane_wide: assert property (p_lane_wide) else $error("lane code wrong"); // RULE1

  property p_mem_strobe;
    @(posedge clk_sys_i) disable iff (rst_i)
      cpu_mem_i |-> !io_read_strobe_o && !io_write_strobe_o;
  endproperty
  a_mem_strobe: assert property (p_mem_strobe) else $error("io strobe on mem"); // RULE2

  property p_dyn_size;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy && dyn_wide |-> size_sixteen_indicate_o && !size_eight_indicate_o;
  endproperty
  a_dyn_size: assert property (p_dyn_size) else $error("size not sixteen"); // RULE5

  property p_eight_size;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy && !wide_r && !dyn_wide |-> size_eight_indicate_o;
  endproperty
  a_eight_size: assert property (p_eight_size) else $error("size not eight"); // RULE23

  property p_wait_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_WAIT && !ready_seen |=> strobe_on;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("strobe ended early"); // RULE12

  property p_pulse_full;
    @(posedge clk_sys_i) disable iff (rst_i)
      $rose(strobe_on) |-> strobe_on throughout (##[0:15] cnt_r == 4'h0);
  endproperty
  a_pulse_full: assert property (p_pulse_full) else $error("pulse cut short"); // RULE10

  property p_ready_end;
    @(posedge clk_sys_i) disable iff (rst_i)
      $fell(strobe_on) |-> $past(ready_seen);
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("ended without ready"); // RULE13

  property p_no_ext;
    @(posedge clk_sys_i) disable iff (rst_i)
      !ext_enable && !busy |=> !busy;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("bus ran while off"); // RULE18

  property p_exact_end;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_PULSE && cnt_r == 4'h0 && ready_seen |=> state_r == ST_IDLE;
  endproperty
  a_exact_end: assert property (p_exact_end) else $error("extra cycle added"); // RULE24

  property p_lock;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy |-> cpu_lock_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock dropped"); // RULE14

  property p_rst_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      wr_reset_configuration |=> ext_bus_reset_out_o == $past(reg_wdata_i[BUS_RESET_BIT_POS]);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("bus reset wrong"); // RULE19

  property p_lane_eight;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy && !cur_wide |-> byte_high_enable_o && (addr_bit_zero_o == cpu_a0_i);
  endproperty
  a_lane_eight: assert property (p_lane_eight) else $error("eight bit lane wrong"); // RULE1

  property p_late_ready;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_PULSE && cnt_r == 4'h0 && !ready_seen |=> state_r == ST_WAIT;
  endproperty
  a_late_ready: assert property (p_late_ready) else $error("wait not entered"); // RULE9

  property p_qual_cs;
    @(posedge clk_sys_i) disable iff (rst_i)
      busy && qual_r[cpu_cs_i] && !strobe_on |-> ext_chip_selects_o == '0;
  endproperty
  a_qual_cs: assert property (p_qual_cs) else $error("select not qualified"); // RULE22

  property p_sys_bus_rst;
    @(posedge clk_sys_i)
      rst_i |-> ext_bus_reset_out_o;
  endproperty
  a_sys_bus_rst: assert property (p_sys_bus_rst) else $error("no bus reset"); // RULE19

  property p_rst_cs;
    @(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> ext_chip_selects_o == '0 && !busy;
  endproperty
  a_rst_cs: assert property (p_rst_cs) else $error("select on after reset"); // RULE17

  property p_done_end;
    @(posedge clk_sys_i) disable iff (rst_i)
      done_o |=> !busy;
  endproperty
  a_done_end: assert property (p_done_end) else $error("cycle ran past done"); // RULE13

  c_wait:   cover property (@(posedge clk_sys_i) state_r == ST_WAIT);
  c_dyn:    cover property (@(posedge clk_sys_i) busy && dyn_wide && !wide_r);
  c_mem_wr: cover property (@(posedge clk_sys_i) mem_write_strobe_o);
  c_qual:   cover property (@(posedge clk_sys_i) busy && qual_r[cpu_cs_i] && strobe_on);
  c_upper:  cover property (@(posedge clk_sys_i) !byte_high_enable_o && addr_bit_zero_o);
endmodule
`default_nettype wire

// ---- gp_bus_pkg.sv ----
/*
  package for the general purpose bus cycle controller: register offsets,
  field positions, reset values and cycle states.
  assumes a single clock domain and a plain register port.
*/
`default_nettype none
package gp_bus_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OFS_BUS_ECHO_CONTROL       = 12'hC00;
  localparam logic [11:0] OFS_CHIPSEL_WIDTH_SELECT   = 12'hC01;
  localparam logic [11:0] OFS_CHIPSEL_STROBE_QUALIFY = 12'hC02;
  localparam logic [11:0] OFS_CHIPSEL_PIN_FUNCTION   = 12'hC24;
  localparam logic [11:0] OFS_RESET_CONFIGURATION    = 12'hD72;
  localparam logic [11:0] OFS_STROBE_TIMING          = 12'hC10;
  localparam logic [11:0] OFS_BUS_CONTROL            = 12'hC11;
  localparam logic [11:0] OFS_BUS_STATUS             = 12'hC12;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          BUS_RESET_BIT_POS  = 0;
  localparam int          REGIONS_DONE_POS   = 0;
  localparam int          IO_HOLES_EN_POS    = 1;
  localparam int          PULSE_LSB          = 0;
  localparam int          OFFSET_LSB         = 4;
  localparam logic [7:0]  CTRL_RESET         = 8'h02;
  localparam logic [7:0]  TIMING_RESET       = 8'h00;
  localparam logic [7:0]  ZERO_RESET         = 8'h00;
  localparam int          SYNC_STAGES        = 2;
  // ****************************************
  // cycle states
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_OFFSET, ST_PULSE, ST_WAIT} cyc_state_t;
endpackage
`default_nettype wire

// ---- ready_sync.sv ----
/*
  two flip-flop synchroniser for the external ready input.
  assumes the input may change at any time relative to clk_sys_i.
*/
`default_nettype none
module ready_sync
  import gp_bus_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  // ****************************************
  // two stages, first read only by second
  // ****************************************
  logic meta_r;
  logic sync_r;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule
`default_nettype wire

// ---- gp_periph_model.sv ----
/*
  model of an external bus peripheral: drives ready and the sizing inputs.
  assumes active high chip selects and strobes from the bus controller.
*/
`default_nettype none
module gp_periph_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       valid_i,
  input  wire logic       mem_i,
  input  wire logic       bus_reset_i,
  input  wire logic       size_en_i,
  input  wire logic [7:0] wait_len_i,
  output logic            ready_o,
  output logic            io_wide_o,
  output logic            mem_wide_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  logic       wide_r;
  // ****************************************
  // ready and sizing
  // ****************************************
  // registered so both change only after a clock edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus_reset_i || !valid_i) begin
      cnt_r   <= wait_len_i;
      ready_o <= 1'b1;
      wide_r  <= 1'b0;
    end else begin
      wide_r  <= size_en_i;
      ready_o <= (cnt_r == 8'h00);
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  assign io_wide_o  = wide_r & ~mem_i;
  assign mem_wide_o = wide_r & mem_i;
endmodule
`default_nettype wire

// ---- gp_bus_cycle_sizing_wait_bench.sv ----
/*
  self-checking bench for the bus cycle controller.
  assumes the peripheral model and the package are compiled first.
*/
`default_nettype none
module gp_bus_cycle_sizing_wait_bench
  import gp_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] cs;
    logic [5:0] f;
    logic [9:0] exp;
  } row_t;
  logic        clk_sys_i, rst_i, reg_wr_i, reg_rd_i, cpu_req_i, cpu_write_i;
  logic        cpu_mem_i, cpu_a0_i, cpu_wide_i, cpu_split_i, size_en, done_o;
  logic        size_sixteen_indicate_o, size_eight_indicate_o, noncacheable_o;
  logic        cpu_lock_o, byte_high_enable_o, addr_bit_zero_o, io_read_strobe_o;
  logic        io_write_strobe_o, mem_read_strobe_o, mem_write_strobe_o;
  logic        ext_bus_reset_out_o, echo_enable_o, io_wide_select_in_i;
  logic        mem_wide_select_in_i, wait_ready_in_i;
  logic [11:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, ext_chip_selects_o, wait_len, tim [4];
  logic [2:0]  cpu_cs_i;
  logic [10:0] ext_irq_lines_i, irq_ctrl_lines_o;
  logic [9:0]  snap;
  int          bad_count, compares, cycles, d, d0, d1, d2;
  row_t        rows [8];
  gp_bus_cycle_sizing_wait #(.NUM_CS(8)) u_dut (
    .clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .cpu_req_i, .cpu_write_i, .cpu_mem_i, .cpu_cs_i, .cpu_a0_i, .cpu_wide_i, .cpu_split_i,
    .done_o, .size_sixteen_indicate_o, .size_eight_indicate_o, .noncacheable_o,
    .cpu_lock_o, .byte_high_enable_o, .addr_bit_zero_o, .io_read_strobe_o,
    .io_write_strobe_o, .mem_read_strobe_o, .mem_write_strobe_o, .ext_chip_selects_o,
    .ext_bus_reset_out_o, .echo_enable_o, .io_wide_select_in_i, .mem_wide_select_in_i,
    .wait_ready_in_i, .ext_irq_lines_i, .irq_ctrl_lines_o
  );
  gp_periph_model u_periph (
    .clk_sys_i, .rst_i,
    .valid_i     (|ext_chip_selects_o | io_read_strobe_o | io_write_strobe_o |
                  mem_read_strobe_o | mem_write_strobe_o),
    .mem_i       (cpu_mem_i),
    .bus_reset_i (ext_bus_reset_out_o),
    .size_en_i   (size_en),
    .wait_len_i  (wait_len),
    .ready_o     (wait_ready_in_i),
    .io_wide_o   (io_wide_select_in_i),
    .mem_wide_o  (mem_wide_select_in_i)
  );
  // ****************************************
  // checking and register tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, v);
  endtask
  // one bus cycle; flags are write, mem, a0, wide, split, sizing
  task automatic cyc(input logic [2:0] cs, input logic [5:0] f, output int n);
    @(posedge clk_sys_i);
    cpu_cs_i <= cs;
    {cpu_write_i, cpu_mem_i, cpu_a0_i, cpu_wide_i, cpu_split_i} <= f[5:1];
    size_en   <= f[0];
    cpu_req_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (done_o !== 1'b1 && n < 300);
    if (n >= 300) check(n, 0);
    snap = {byte_high_enable_o, addr_bit_zero_o, size_sixteen_indicate_o,
            size_eight_indicate_o, io_read_strobe_o, io_write_strobe_o,
            mem_read_strobe_o, mem_write_strobe_o, cpu_lock_o, ext_chip_selects_o[cs]};
    @(posedge clk_sys_i);
    cpu_req_i <= 1'b0;
  endtask
  // ****************************************
  // clock, timeout, sequence
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // whole run is near 260 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    rows = '{{3'h0, 6'h04, 10'h0A3}, {3'h1, 6'h3A, 10'h187}, {3'h4, 6'h00, 10'h263},
             {3'h4, 6'h28, 10'h353}, {3'h5, 6'h15, 10'h08B}, {3'h6, 6'h29, 10'h193},
             {3'h7, 6'h04, 10'h263}, {3'h3, 6'h34, 10'h087}};
    tim = '{8'h23, 8'h07, 8'hFF, 8'h00};
    {rst_i, reg_wr_i, reg_rd_i, cpu_req_i, cpu_write_i, cpu_mem_i} = 6'h20;
    {cpu_a0_i, cpu_wide_i, cpu_split_i, size_en} = 4'h0;
    {reg_addr_i, reg_wdata_i, cpu_cs_i, wait_len} = 31'h0;
    ext_irq_lines_i = 11'h5A5;
    repeat (2) @(posedge clk_sys_i);
    #1 check(ext_bus_reset_out_o, 1);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rc(OFS_BUS_CONTROL, 8'h02);
    rc(OFS_CHIPSEL_PIN_FUNCTION, 8'h00);
    rc(OFS_CHIPSEL_WIDTH_SELECT, 8'h00);
    rc(OFS_RESET_CONFIGURATION, 8'h00);
    rc(12'h123, 8'h00);
    check({done_o, io_read_strobe_o, ext_chip_selects_o}, 0);
    cpu_req_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1 check({done_o, io_read_strobe_o, io_write_strobe_o}, 0);
    cpu_req_i <= 1'b0;
    wr(OFS_BUS_CONTROL, 8'h03);
    wr(OFS_CHIPSEL_PIN_FUNCTION, 8'hFF);
    wr(OFS_STROBE_TIMING, 8'h03);
    wr(OFS_CHIPSEL_WIDTH_SELECT, 8'h0F);
    wr(OFS_BUS_ECHO_CONTROL, 8'h01);
    rc(OFS_CHIPSEL_WIDTH_SELECT, 8'h0F);
    rc(OFS_CHIPSEL_PIN_FUNCTION, 8'hFF);
    check(echo_enable_o, 1);
    check(noncacheable_o, 1);
    check(irq_ctrl_lines_o, 11'h5A5);
    ext_irq_lines_i = 11'h25A;
    #1 check(irq_ctrl_lines_o, 11'h25A);
    cyc(3'h0, 6'h04, d0);
    foreach (rows[i]) begin
      cyc(rows[i].cs, rows[i].f, d);
      check(snap, rows[i].exp);
      check(d, d0);
    end
    foreach (tim[i]) begin
      wr(OFS_STROBE_TIMING, tim[i]);
      cyc(3'h0, 6'h04, d);
      check(d, d0 + tim[i][7:4] + tim[i][3:0] - 3);
    end
    wr(OFS_STROBE_TIMING, 8'h02);
    cyc(3'h2, 6'h00, d1);
    check(d1, d0 - 1);
    wait_len <= 8'h01;
    cyc(3'h2, 6'h00, d);
    check(d >= d1, 1);
    wait_len <= 8'h0C;
    cyc(3'h2, 6'h00, d);
    wait_len <= 8'h10;
    cyc(3'h2, 6'h00, d2);
    check(d > d1, 1);
    check(d2 - d, 4);
    wait_len <= 8'h00;
    // qualified select stays low through the offset, then follows the strobe
    wr(OFS_CHIPSEL_STROBE_QUALIFY, 8'h04);
    wr(OFS_STROBE_TIMING, 8'h32);
    cpu_req_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 check({ext_chip_selects_o, io_read_strobe_o}, 9'h000);
    repeat (3) @(posedge clk_sys_i);
    #1 check({ext_chip_selects_o, io_read_strobe_o}, 9'h009);
    @(posedge clk_sys_i);
    #1 check(done_o, 1);
    @(posedge clk_sys_i);
    cpu_req_i <= 1'b0;
    wr(OFS_RESET_CONFIGURATION, 8'h01);
    #1 check(ext_bus_reset_out_o, 1);
    wr(OFS_RESET_CONFIGURATION, 8'h00);
    #1 check(ext_bus_reset_out_o, 0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 check(ext_bus_reset_out_o, 1);
    rst_i <= 1'b0;
    rc(OFS_CHIPSEL_WIDTH_SELECT, 8'h00);
    rc(OFS_BUS_CONTROL, 8'h02);
    results();
  end
endmodule
`default_nettype wire
